// *** rtl/csc_curve.v ***
// Closed-loop speed curve: maps the duty command to a target speed.
// Assumes the command is already a duty in 1/512 units, synchronous to
// clk_sys, and that a regulator downstream follows the target speed.
`timescale 1ns/10ps
`include "csc_map.vh"

module csc_curve (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Register access
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wr_data,
    output wire [7:0] reg_rd_data_r,
    // Speed command, duty in 1/512 units
    input wire [9:0] speed_command,
    // Curve outputs
    output reg [19:0] target_speed_r,
    output reg open_drive_r,
    output reg [9:0] out_duty_r,
    output reg closed_loop_r,
    output reg motor_run_r
);

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    wire [6:0] halt_duty_code;
    wire never_halt_bit;
    wire [7:0] start_duty_code;
    wire [7:0] breakpoint_duty_code;
    wire [7:0] top_duty_code;
    wire [11:0] initial_speed_code;
    wire [3:0] top_band_hysteresis;
    wire [13:0] first_slope_code;
    wire open_top_band_bit;
    wire zero_means_full_bit;
    wire [13:0] second_slope_code;
    wire loop_select_bit;

    csc_regs u_regs (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data),
        .reg_rd_data_r(reg_rd_data_r),
        .halt_duty_code(halt_duty_code),
        .never_halt_bit(never_halt_bit),
        .start_duty_code(start_duty_code),
        .breakpoint_duty_code(breakpoint_duty_code),
        .top_duty_code(top_duty_code),
        .initial_speed_code(initial_speed_code),
        .top_band_hysteresis(top_band_hysteresis),
        .first_slope_code(first_slope_code),
        .open_top_band_bit(open_top_band_bit),
        .zero_means_full_bit(zero_means_full_bit),
        .second_slope_code(second_slope_code),
        .loop_select_bit(loop_select_bit)
    );

    // ------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------
    // Positive part of a difference, zero when b is above a
    function [9:0] excess;
        input [9:0] a;
        input [9:0] b;
        begin
            excess = (a > b) ? (a - b) : `CSC_DUTY_ZERO;
        end
    endfunction

    // Speed after a straight segment: base + slope x span / 64
    function [19:0] seg_speed;
        input [19:0] base;
        input [13:0] slope;
        input [9:0] span;
        reg [23:0] prod;
        begin
            prod = {10'h000, slope} * {14'h0000, span};
            seg_speed = base + {2'b00, prod[23:`CSC_SLOPE_SHIFT]};
        end
    endfunction

    // Full curve at duty d, d already clamped to top duty
    function [19:0] curve_at;
        input [9:0] d;
        input bp_on;
        input [9:0] bp_d;
        input [19:0] bp_spd;
        input [9:0] st_d;
        input [19:0] st_spd;
        input [13:0] s1;
        input [13:0] s2;
        begin
            if (bp_on && (d > bp_d)) begin
                curve_at = seg_speed(bp_spd, s2, excess(d, bp_d));
            end else begin
                curve_at = seg_speed(st_spd, s1, excess(d, st_d));
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Duty thresholds
    // ------------------------------------------------------------
    // saturate to full duty
    wire [9:0] cmd = (speed_command > `CSC_DUTY_FULL) ?
        `CSC_DUTY_FULL : speed_command;

    wire [9:0] start_duty = {2'b00, start_duty_code};
    wire [9:0] halt_duty = {2'b00, halt_duty_code, 1'b0};
    wire [9:0] top_duty = {2'b00, top_duty_code} + `CSC_TOP_OFFSET;

    wire [9:0] bp_duty = {1'b0, breakpoint_duty_code, 1'b0};

    wire [4:0] hys_steps = {1'b0, top_band_hysteresis} + 5'h01;
    wire [9:0] return_duty = top_duty - {4'h0, hys_steps, 1'b0};

    wire [19:0] start_speed = {8'h00, initial_speed_code};

    // ------------------------------------------------------------
    // Curve evaluation
    // ------------------------------------------------------------
    // zero code disables breakpoint
    // misplaced breakpoint falls back to one slope
    wire bp_on = (breakpoint_duty_code != `CSC_BP_NONE) &&
        (bp_duty > start_duty) && (bp_duty < top_duty);

    wire [19:0] bp_speed = seg_speed(start_speed, first_slope_code,
        excess(bp_duty, start_duty));

    wire [9:0] cmd_clamped = (cmd > top_duty) ? top_duty : cmd;

    wire [19:0] cmd_speed = curve_at(cmd_clamped, bp_on, bp_duty, bp_speed,
        start_duty, start_speed, first_slope_code, second_slope_code);

    wire [19:0] top_speed = curve_at(top_duty, bp_on, bp_duty, bp_speed,
        start_duty, start_speed, first_slope_code, second_slope_code);

    // ------------------------------------------------------------
    // Command zones
    // ------------------------------------------------------------
    wire zone_zero = (cmd == `CSC_DUTY_ZERO);
    wire zone_low = !zone_zero && (cmd <= halt_duty);
    wire zone_band = !zone_zero && !zone_low && (cmd <= start_duty);
    wire zone_top = (cmd >= top_duty);

    // with never-halt, full request up to halt duty
    wire full_req = zero_means_full_bit &&
        (zone_zero || (never_halt_bit && zone_low));

    // ------------------------------------------------------------
    // Run and open-band state
    // ------------------------------------------------------------
    // Run state gives the band its hysteresis: a stopped motor stays
    // stopped until start duty, a running one runs down to halt duty.
    reg run_nxt;
    reg open_band_r;
    reg open_band_nxt;

    always @* begin
        run_nxt = motor_run_r;
        if (cmd > start_duty) begin
            run_nxt = 1'b1;
        end else if (cmd <= halt_duty) begin
            run_nxt = 1'b0;
        end
    end

    always @* begin
        open_band_nxt = open_band_r;
        if (!open_top_band_bit || loop_select_bit) begin
            open_band_nxt = 1'b0;
        // enter open band at top duty
        end else if (zone_top) begin
            open_band_nxt = 1'b1;
        end else if (cmd <= return_duty) begin
            open_band_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    // Priority: loop select, full request, low zones, open band, curve.
    // breakpoint curve shared by the full request, open band and curve options below
    reg [19:0] speed_nxt;
    reg open_nxt;
    reg [9:0] duty_nxt;
    reg closed_nxt;

    always @* begin
        speed_nxt = `CSC_SPEED_ZERO;
        open_nxt = 1'b0;
        duty_nxt = `CSC_DUTY_ZERO;
        closed_nxt = 1'b1;
        if (loop_select_bit) begin
            closed_nxt = 1'b0;
        end else if (full_req) begin
            speed_nxt = top_speed;
            if (open_top_band_bit) begin
                open_nxt = 1'b1;
                duty_nxt = `CSC_DUTY_FULL;
            end
        end else if (zone_zero || zone_low) begin
            speed_nxt = never_halt_bit ? start_speed : `CSC_SPEED_ZERO;
        end else if (zone_band) begin
            speed_nxt = (never_halt_bit || motor_run_r) ?
                start_speed : `CSC_SPEED_ZERO;
        end else if (open_band_nxt) begin
            speed_nxt = top_speed;
            open_nxt = 1'b1;
            duty_nxt = cmd;
        end else begin
            speed_nxt = cmd_speed;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            target_speed_r <= `CSC_SPEED_ZERO;
            open_drive_r <= 1'b0;
            out_duty_r <= `CSC_DUTY_ZERO;
            closed_loop_r <= 1'b1;
            motor_run_r <= 1'b0;
            open_band_r <= 1'b0;
        end else begin
            target_speed_r <= speed_nxt;
            open_drive_r <= open_nxt;
            out_duty_r <= duty_nxt;
            closed_loop_r <= closed_nxt;
            motor_run_r <= run_nxt;
            open_band_r <= open_band_nxt;
        end
    end

endmodule

// *** shared/csc_map.vh ***
// Register map, field positions and duty constants of the speed curve.
// Assumes byte registers written by the serial interface logic outside.
//
// Contract
// - Start, stop and top duty thresholds decode from codes in 1/512 units; stop duty here is its code times two, top duty its code plus 257, over 512.
// - Initial speed is a 12-bit rpm code over high byte and upper nibble of low byte.
// - First slope code is 14 bits, 0.08 rpm per percent per step.
// - No top speed is stored; it follows from the curve at top duty.
// - Open band returns to closed loop at top minus (hyst+1) x 0.4%.
// - Flags clear: zero at or below halt duty, hysteresis up to start.
// - Zero-means-full makes 0% a full request, speed or 100% output.
// - Never-halt holds start speed low; with zero-full, full up to halt.
// - Breakpoint duty is its code times two over 512.
// - First slope runs from start duty to the breakpoint.
// - Second slope runs from breakpoint to top, from breakpoint speed.
// - Breakpoint code zero means a single slope to top duty.
// - Breakpoint works together with open band and low-command options.
// - Speed command is resolved to 9-bit duty, 1/512 units.
// - Loop select bit 0 is closed loop, 1 is open loop.
// - Open band: output duty equals input duty at or above top duty.
`ifndef CSC_MAP_VH
`define CSC_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CSC_ADDR_HALT 8'h02
`define CSC_ADDR_START 8'h03
`define CSC_ADDR_BP 8'h04
`define CSC_ADDR_TOP 8'h05
`define CSC_ADDR_SPD_HI 8'h06
`define CSC_ADDR_SPD_LO 8'h07
`define CSC_ADDR_S1_HI 8'h08
`define CSC_ADDR_S1_LO 8'h09
`define CSC_ADDR_S2_HI 8'h0A
`define CSC_ADDR_S2_LO 8'h0B
`define CSC_REG_RST 8'h00
`define CSC_RD_NONE 8'h00
`define CSC_BP_NONE 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CSC_NEVER_HALT_BIT 7
`define CSC_OPEN_TOP_BIT 1
`define CSC_ZERO_FULL_BIT 0
`define CSC_LOOP_SEL_BIT 0

// ------------------------------------------------------------
// Duty scale, 1/512 units
// ------------------------------------------------------------
`define CSC_DUTY_FULL 10'h200
`define CSC_TOP_OFFSET 10'h101
`define CSC_DUTY_ZERO 10'h000
`define CSC_SPEED_ZERO 20'h00000
`define CSC_SLOPE_SHIFT 6

`endif

// *** rtl/csc_regs.v ***
// Byte register file of the speed curve, with field decode.
// Assumes one write or read strobe per access from the serial interface.
`timescale 1ns/10ps
`include "csc_map.vh"

module csc_regs (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Byte access
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wr_data,
    output reg [7:0] reg_rd_data_r,
    // Decoded fields
    output wire [6:0] halt_duty_code,
    output wire never_halt_bit,
    output wire [7:0] start_duty_code,
    output wire [7:0] breakpoint_duty_code,
    output wire [7:0] top_duty_code,
    output wire [11:0] initial_speed_code,
    output wire [3:0] top_band_hysteresis,
    output wire [13:0] first_slope_code,
    output wire open_top_band_bit,
    output wire zero_means_full_bit,
    output wire [13:0] second_slope_code,
    output wire loop_select_bit
);

    reg [7:0] regs_r [0:9];
    integer i;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function in_map;
        input [7:0] a;
        begin
            in_map = (a >= `CSC_ADDR_HALT) && (a <= `CSC_ADDR_S2_LO);
        end
    endfunction

    wire [7:0] idx_full = reg_addr - `CSC_ADDR_HALT;
    wire [3:0] idx = idx_full[3:0];

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            for (i = 0; i < 10; i = i + 1) begin
                regs_r[i] <= `CSC_REG_RST;
            end
            reg_rd_data_r <= `CSC_RD_NONE;
        end else begin
            if (reg_wr_en && in_map(reg_addr)) begin
                regs_r[idx] <= reg_wr_data;
            end
            // Unmapped reads answer zero
            if (reg_rd_en) begin
                reg_rd_data_r <= in_map(reg_addr) ? regs_r[idx] : `CSC_RD_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    assign halt_duty_code = regs_r[0][6:0];
    assign never_halt_bit = regs_r[0][`CSC_NEVER_HALT_BIT];
    assign start_duty_code = regs_r[1];
    assign breakpoint_duty_code = regs_r[2];
    assign top_duty_code = regs_r[3];
    assign initial_speed_code = {regs_r[4], regs_r[5][7:4]};
    assign top_band_hysteresis = regs_r[5][3:0];
    assign first_slope_code = {regs_r[6], regs_r[7][7:2]};
    assign open_top_band_bit = regs_r[7][`CSC_OPEN_TOP_BIT];
    assign zero_means_full_bit = regs_r[7][`CSC_ZERO_FULL_BIT];
    assign second_slope_code = {regs_r[8], regs_r[9][7:2]};
    assign loop_select_bit = regs_r[9][`CSC_LOOP_SEL_BIT];

endmodule

// *** verification/csc_cmd_src.sv ***
// Command source model for the speed curve block.
// Assumes the bench sets the request just after a clock edge.
`timescale 1ns/10ps
module csc_cmd_src (
    // Clock
    input logic clk_sys,
    // Request and command
    input logic [9:0] level_req,
    output logic [9:0] speed_command = 10'h000
);
    // ten-bit duty code
    // Codes above full scale pass, so the block's own saturation is hit
    always @(posedge clk_sys) begin
        speed_command <= level_req;
    end
endmodule

// *** verification/csc_curve_monitor.sv ***
// Assertion checker for the speed curve top, bound below.
// Assumes one clock clk_sys and synchronous active-high sys_rst.
`timescale 1ns/10ps
module csc_curve_monitor (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    // Register access
    input logic reg_wr_en,
    input logic reg_rd_en,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wr_data,
    input logic [7:0] reg_rd_data_r,
    // Command and curve outputs
    input logic [9:0] speed_command,
    input logic [19:0] target_speed_r,
    input logic open_drive_r,
    input logic [9:0] out_duty_r,
    input logic closed_loop_r,
    input logic motor_run_r
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_wr_start;
        reg_wr_en && reg_addr == 8'h03;
    endsequence
    sequence s_rd_start;
        reg_rd_en && !reg_wr_en && reg_addr == 8'h03;
    endsequence
    sequence s_quiet;
        $stable(speed_command) && !reg_wr_en;
    endsequence
    AST_WR_RD: assert property (s_wr_start ##1 !reg_wr_en ##1
        s_rd_start |=> reg_rd_data_r == $past(reg_wr_data, 3))
        else $error("readback bad");
    AST_UNMAP: assert property (reg_rd_en &&
        (reg_addr < 8'h02 || reg_addr > 8'h0B) |=> reg_rd_data_r == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!reg_rd_en |=>
        $stable(reg_rd_data_r)) else $error("read data moved");
    AST_OPEN_DUTY: assert property (open_drive_r |->
        out_duty_r == $past(speed_command) || out_duty_r == 10'h200)
        else $error("open duty mismatch");
    AST_SHUT_DUTY: assert property (!open_drive_r |->
        out_duty_r == 10'h000) else $error("duty while closed");
    AST_LOOP_OFF: assert property (!closed_loop_r |->
        target_speed_r == 20'h00000 && !open_drive_r)
        else $error("open loop output not idle");
    AST_RST: assert property ($past(sys_rst) |->
        target_speed_r == 20'h00000 && closed_loop_r && !motor_run_r)
        else $error("reset state wrong");
    AST_RUN_UP: assert property ($rose(motor_run_r) |->
        $past(speed_command) != 10'h000) else $error("run from zero");
    AST_SETTLE: assert property (s_quiet [*3] |=>
        $stable(target_speed_r)) else $error("target drifts");
endmodule
bind csc_curve csc_curve_monitor u_mon (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data_r(reg_rd_data_r), .speed_command(speed_command),
    .target_speed_r(target_speed_r), .open_drive_r(open_drive_r),
    .out_duty_r(out_duty_r), .closed_loop_r(closed_loop_r),
    .motor_run_r(motor_run_r));

// *** verification/csc_curve_test.sv ***
// Self-checking bench of the speed curve block.
// Assumes the command source model and the bound checker.
`timescale 1ns/10ps
module csc_curve_test;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [9:0] level_req = 10'h000;
    logic [7:0] rd_val;
    wire [7:0] reg_rd_data_r;
    wire [9:0] speed_command;
    wire [9:0] out_duty_r;
    wire [19:0] target_speed_r;
    wire open_drive_r;
    wire closed_loop_r;
    wire motor_run_r;
    int error_cnt = 0;
    int total_checks = 0;
    // Base curve 0x02..0x0B: start 102, halt 92, top 461, 1500 rpm
    logic [7:0] img [10] = '{8'h2E, 8'h66, 8'h00, 8'hCC, 8'h5D,
        8'hC9, 8'h25, 8'h9C, 8'h30, 8'hC8};

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    csc_cmd_src src (.clk_sys(clk_sys), .level_req(level_req),
        .speed_command(speed_command));
    csc_curve uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data_r(reg_rd_data_r), .speed_command(speed_command),
        .target_speed_r(target_speed_r), .open_drive_r(open_drive_r),
        .out_duty_r(out_duty_r), .closed_loop_r(closed_loop_r),
        .motor_run_r(motor_run_r));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic check(input string n, input logic [19:0] e,
        input logic [19:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Idle edge after each strobe keeps back-to-back calls legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick(1);
        rd_val = reg_rd_data_r;
        reg_rd_en = 1'b0;
        tick(1);
    endtask
    // Source adds one stage, design one, hysteresis state one more
    task automatic go(input logic [9:0] c, input logic [19:0] s,
        input logic od, input logic [9:0] du);
        level_req = c;
        tick(3);
        check("target", s, target_speed_r);
        check("open_drive", od, open_drive_r);
        check("out_duty", du, out_duty_r);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] a;
        rd(8'h03);
        check("reset code", 20'h00000, rd_val);
        for (int i = 0; i < 10; i++) begin
            a = 8'h02 + 8'(i);
            wr(a, img[i]);
        end
        wr(8'h03, 8'h66);
        rd(8'h03);
        check("start code", 20'h00066, rd_val);
        for (int i = 0; i < 10; i++) begin
            a = 8'h02 + 8'(i);
            rd(a);
            check("readback", {12'h000, img[i]}, rd_val);
        end
        wr(8'h0C, 8'h55);
        rd(8'h0C);
        check("unmapped", 20'h00000, rd_val);
        rd(8'h01);
        check("unmapped", 20'h00000, rd_val);
    endtask
    task automatic t_curve;
        go(10'h12C, 20'h022F2, 1'b0, 10'h000);
        go(10'h1CD, 20'h03A99, 1'b0, 10'h000);
        go(10'h200, 20'h03A99, 1'b0, 10'h000);
        go(10'h3FF, 20'h03A99, 1'b0, 10'h000);
        check("closed", 1'b1, closed_loop_r);
    endtask
    task automatic t_low;
        go(10'h000, 20'h00000, 1'b0, 10'h000);
        go(10'h064, 20'h00000, 1'b0, 10'h000);
        go(10'h0C8, 20'h01441, 1'b0, 10'h000);
        go(10'h064, 20'h005DC, 1'b0, 10'h000);
        check("run", 1'b1, motor_run_r);
        go(10'h05C, 20'h00000, 1'b0, 10'h000);
        go(10'h060, 20'h00000, 1'b0, 10'h000);
        check("run", 1'b0, motor_run_r);
    endtask
    task automatic t_open;
        wr(8'h09, 8'h9E);
        go(10'h1E0, 20'h03A99, 1'b1, 10'h1E0);
        go(10'h1BB, 20'h03A99, 1'b1, 10'h1BB);
        go(10'h1B9, 20'h037A9, 1'b0, 10'h000);
    endtask
    task automatic t_full;
        wr(8'h09, 8'h9D);
        go(10'h000, 20'h03A99, 1'b0, 10'h000);
        go(10'h032, 20'h00000, 1'b0, 10'h000);
        wr(8'h09, 8'h9F);
        go(10'h000, 20'h03A99, 1'b1, 10'h200);
        wr(8'h02, 8'hAE);
        go(10'h032, 20'h03A99, 1'b1, 10'h200);
        go(10'h060, 20'h005DC, 1'b0, 10'h000);
        wr(8'h09, 8'h9C);
        go(10'h000, 20'h005DC, 1'b0, 10'h000);
        go(10'h032, 20'h005DC, 1'b0, 10'h000);
        wr(8'h02, 8'h2E);
    endtask
    task automatic t_bp;
        wr(8'h04, 8'h80);
        go(10'h0C8, 20'h01441, 1'b0, 10'h000);
        go(10'h100, 20'h01C7B, 1'b0, 10'h000);
        go(10'h190, 20'h037EB, 1'b0, 10'h000);
        wr(8'h09, 8'h9E);
        go(10'h1E0, 20'h0438B, 1'b1, 10'h1E0);
        wr(8'h09, 8'h9C);
        wr(8'h04, 8'h00);
    endtask
    task automatic t_loop;
        wr(8'h0B, 8'hC9);
        go(10'h12C, 20'h00000, 1'b0, 10'h000);
        check("closed", 1'b0, closed_loop_r);
        wr(8'h0B, 8'hC8);
        go(10'h12C, 20'h022F2, 1'b0, 10'h000);
    endtask
    // Mid-run reset from a running, configured state
    task automatic t_reset;
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        check("rst target", 20'h00000, target_speed_r);
        check("rst run", 1'b0, motor_run_r);
        check("rst closed", 1'b1, closed_loop_r);
        check("rst open", 1'b0, open_drive_r);
        check("rst duty", 20'h00000, out_duty_r);
        rd(8'h0B);
        check("rst reg", 20'h00000, rd_val);
        go(10'h12C, 20'h00000, 1'b0, 10'h000);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        tick(2);
        sys_rst = 1'b0;
        t_regs();
        t_curve();
        t_low();
        t_open();
        t_full();
        t_bp();
        t_loop();
        t_reset();
        wrap_up();
    end
endmodule
